// ==== pkg/xma_map.svh ====
`ifndef XMA_MAP_SVH
`define XMA_MAP_SVH

// ----------------------------------------------------------------
// apb register offsets
// ----------------------------------------------------------------
`define XMA_OFF_WORK    12'h000
`define XMA_OFF_FLAGS   12'h004
`define XMA_OFF_MEM     12'h008
`define XMA_OFF_CMD     12'h00c
`define XMA_OFF_RESULT  12'h010
`define XMA_OFF_STATUS  12'h014

// ----------------------------------------------------------------
// flag bit positions in the flags register
// ----------------------------------------------------------------
`define XMA_FLG_CARRY   0
`define XMA_FLG_HALF    1
`define XMA_FLG_ZERO    2
`define XMA_FLG_WRAP    3
`define XMA_FLG_SIGNED  4
`define XMA_FLG_CHAINZ  5

// ----------------------------------------------------------------
// command field positions, reset value and fixed constants
// ----------------------------------------------------------------
`define XMA_CMD_OP_LSB  0
`define XMA_CMD_OP_MSB  4
`define XMA_CMD_BIT_LSB 8
`define XMA_CMD_BIT_MSB 10
`define XMA_RST_BYTE    8'h00
`define XMA_ALL_ONES    8'hff
`define XMA_SKIP_CYCLES 2'h3
`endif

// ==== pkg/xma_pkg.sv ====
package xma_pkg;
    // operation codes written to the command register
    typedef enum logic [4:0] {
        XMA_MEM_ROTATE_LEFT            = 5'h00,
        XMA_ROTATE_LEFT_TO_WORK        = 5'h01,
        XMA_ROTATE_LEFT_THRU_CARRY     = 5'h02,
        XMA_ROTATE_LEFT_THRU_CARRY_TO_WORK  = 5'h03,
        XMA_MEM_ROTATE_RIGHT           = 5'h04,
        XMA_ROTATE_RIGHT_TO_WORK       = 5'h05,
        XMA_ROTATE_RIGHT_THRU_CARRY    = 5'h06,
        XMA_ROTATE_RIGHT_THRU_CARRY_TO_WORK = 5'h07,
        XMA_SUBTRACT_WITH_BORROW       = 5'h08,
        XMA_SUBTRACT_WITH_BORROW_TO_MEM = 5'h09,
        XMA_PLAIN_SUBTRACT             = 5'h0a,
        XMA_PLAIN_SUBTRACT_TO_MEM      = 5'h0b,
        XMA_DECREMENT_SKIP_ZERO        = 5'h0c,
        XMA_DECREMENT_SKIP_ZERO_TO_WORK = 5'h0d,
        XMA_INCREMENT_SKIP_ZERO        = 5'h0e,
        XMA_INCREMENT_SKIP_ZERO_TO_WORK = 5'h0f,
        XMA_SET_ALL_BITS               = 5'h10,
        XMA_SET_ONE_BIT                = 5'h11,
        XMA_SKIP_IF_BIT_SET            = 5'h12,
        XMA_SKIP_IF_NONZERO            = 5'h13,
        XMA_NIBBLE_EXCHANGE            = 5'h14,
        XMA_NIBBLE_EXCHANGE_TO_WORK    = 5'h15
    } xma_op_e;

    // execution sequencer
    typedef enum logic [1:0] {
        XMA_IDLE  = 2'b00,
        XMA_EXEC  = 2'b01,
        XMA_DUMMY = 2'b10
    } xma_state_e;

    // arithmetic flag set
    typedef struct packed {
        logic chained_zero_flag;
        logic signed_result_flag;
        logic twos_complement_wrap_flag;
        logic zero;
        logic half_carry_flag;
        logic carry;
    } xma_flags_s;

    // one executed result
    typedef struct packed {
        logic [7:0] value;
        logic       to_mem;
        logic       to_work;
        logic       skip;
    } xma_result_s;
endpackage

// ==== src/xma_core.sv ====
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "xma_map.svh"
module xma_core (
    // clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rst_b_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // sequencer view
    output logic             busy_out,
    output logic             skip_out,
    output logic             dummy_out
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0]           work_reg;     // working register
    logic [7:0]           mem_reg;      // addressed memory byte
    xma_pkg::xma_flags_s  flags_reg;    // status flags
    logic [4:0]           op_reg;       // pending operation
    logic [2:0]           bit_reg;      // selected bit
    xma_pkg::xma_state_e  state_reg;    // sequencer state
    logic                 skip_reg;     // last instruction skipped
    logic [1:0]           cyc_reg;      // cycles of last instruction
    xma_pkg::xma_result_s res;          // combinational result
    xma_pkg::xma_flags_s  flags_next;   // combinational flags

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    logic wr_en;
    logic rd_en;
    logic hit;
    assign wr_en       = psel_in & penable_in & pwrite_in;
    assign rd_en       = psel_in & penable_in & ~pwrite_in;
    // zero-wait slave; writes while busy are refused with an error
    assign pready_out  = 1'b1;
    assign hit         = (paddr_in == `XMA_OFF_WORK) | (paddr_in == `XMA_OFF_FLAGS) |
                         (paddr_in == `XMA_OFF_MEM) | (paddr_in == `XMA_OFF_CMD) |
                         (paddr_in == `XMA_OFF_RESULT) | (paddr_in == `XMA_OFF_STATUS);
    assign pslverr_out = psel_in & penable_in & (~hit | (pwrite_in & (state_reg != xma_pkg::XMA_IDLE)));

    logic wr_ok;
    assign wr_ok = wr_en & hit & (state_reg == xma_pkg::XMA_IDLE);

    // ----------------------------------------------------------------
    // datapath: one result per operation, eight bits wide
    // ----------------------------------------------------------------
    logic [8:0] diff;
    logic [4:0] hdiff;
    logic       bin;
    logic [7:0] dec_v;
    logic [7:0] inc_v;
    always_comb begin
        // borrow-in only for the with-borrow forms
        bin = (op_reg == xma_pkg::XMA_SUBTRACT_WITH_BORROW ||
               op_reg == xma_pkg::XMA_SUBTRACT_WITH_BORROW_TO_MEM) ? ~flags_reg.carry : 1'b0;
        diff  = {1'b0, work_reg} - {1'b0, mem_reg} - {8'h00, bin};
        hdiff = {1'b0, work_reg[3:0]} - {1'b0, mem_reg[3:0]} - {4'h0, bin};
        dec_v = mem_reg - 8'h01;
        inc_v = mem_reg + 8'h01;
        res        = '0;
        flags_next = flags_reg;
        case (op_reg)
            xma_pkg::XMA_MEM_ROTATE_LEFT: begin
                res = '{value: {mem_reg[6:0], mem_reg[7]}, to_mem: 1'b1, to_work: 1'b0, skip: 1'b0};
            end
            xma_pkg::XMA_ROTATE_LEFT_TO_WORK: begin
                res = '{value: {mem_reg[6:0], mem_reg[7]}, to_mem: 1'b0, to_work: 1'b1, skip: 1'b0};
            end
            xma_pkg::XMA_ROTATE_LEFT_THRU_CARRY, xma_pkg::XMA_ROTATE_LEFT_THRU_CARRY_TO_WORK: begin
                res.value        = {mem_reg[6:0], flags_reg.carry};
                res.to_mem       = (op_reg == xma_pkg::XMA_ROTATE_LEFT_THRU_CARRY);
                res.to_work      = ~res.to_mem;
                flags_next.carry = mem_reg[7];
            end
            xma_pkg::XMA_MEM_ROTATE_RIGHT: begin
                res = '{value: {mem_reg[0], mem_reg[7:1]}, to_mem: 1'b1, to_work: 1'b0, skip: 1'b0};
            end
            xma_pkg::XMA_ROTATE_RIGHT_TO_WORK: begin
                res = '{value: {mem_reg[0], mem_reg[7:1]}, to_mem: 1'b0, to_work: 1'b1, skip: 1'b0};
            end
            xma_pkg::XMA_ROTATE_RIGHT_THRU_CARRY, xma_pkg::XMA_ROTATE_RIGHT_THRU_CARRY_TO_WORK: begin
                res.value        = {flags_reg.carry, mem_reg[7:1]};
                res.to_mem       = (op_reg == xma_pkg::XMA_ROTATE_RIGHT_THRU_CARRY);
                res.to_work      = ~res.to_mem;
                flags_next.carry = mem_reg[0];
            end
            xma_pkg::XMA_SUBTRACT_WITH_BORROW, xma_pkg::XMA_SUBTRACT_WITH_BORROW_TO_MEM,
            xma_pkg::XMA_PLAIN_SUBTRACT, xma_pkg::XMA_PLAIN_SUBTRACT_TO_MEM: begin
                res.value   = diff[7:0];
                res.to_mem  = (op_reg == xma_pkg::XMA_SUBTRACT_WITH_BORROW_TO_MEM) ||
                              (op_reg == xma_pkg::XMA_PLAIN_SUBTRACT_TO_MEM);
                res.to_work = ~res.to_mem;
                // carry is the inverted borrow out: clear when negative
                flags_next.carry           = ~diff[8];
                flags_next.half_carry_flag = ~hdiff[4];
                flags_next.zero            = (diff[7:0] == `XMA_RST_BYTE);
                flags_next.twos_complement_wrap_flag =
                    (work_reg[7] ^ mem_reg[7]) & (work_reg[7] ^ diff[7]);
                // signed flag is the true sign, corrected for wrap
                flags_next.signed_result_flag = diff[7] ^ flags_next.twos_complement_wrap_flag;
                // chained zero: borrow forms zero only if this and earlier parts were zero; plain forms take this part alone
                flags_next.chained_zero_flag = (op_reg == xma_pkg::XMA_PLAIN_SUBTRACT ||
                    op_reg == xma_pkg::XMA_PLAIN_SUBTRACT_TO_MEM) ? flags_next.zero :
                    (flags_next.zero & flags_reg.chained_zero_flag);
            end
            xma_pkg::XMA_DECREMENT_SKIP_ZERO: begin
                res = '{value: dec_v, to_mem: 1'b1, to_work: 1'b0, skip: dec_v == `XMA_RST_BYTE};
            end
            xma_pkg::XMA_DECREMENT_SKIP_ZERO_TO_WORK: begin
                res = '{value: dec_v, to_mem: 1'b0, to_work: 1'b1, skip: dec_v == `XMA_RST_BYTE};
            end
            xma_pkg::XMA_INCREMENT_SKIP_ZERO: begin
                res = '{value: inc_v, to_mem: 1'b1, to_work: 1'b0, skip: inc_v == `XMA_RST_BYTE};
            end
            xma_pkg::XMA_INCREMENT_SKIP_ZERO_TO_WORK: begin
                res = '{value: inc_v, to_mem: 1'b0, to_work: 1'b1, skip: inc_v == `XMA_RST_BYTE};
            end
            xma_pkg::XMA_SET_ALL_BITS: begin
                res = '{value: `XMA_ALL_ONES, to_mem: 1'b1, to_work: 1'b0, skip: 1'b0};
            end
            xma_pkg::XMA_SET_ONE_BIT: begin
                res.value          = mem_reg;
                res.value[bit_reg] = 1'b1;
                res.to_mem         = 1'b1;
            end
            xma_pkg::XMA_SKIP_IF_BIT_SET: begin
                res.value = mem_reg;
                res.skip  = mem_reg[bit_reg];
            end
            xma_pkg::XMA_SKIP_IF_NONZERO: begin
                // byte is read and written back unchanged
                res = '{value: mem_reg, to_mem: 1'b1, to_work: 1'b0, skip: mem_reg != `XMA_RST_BYTE};
            end
            xma_pkg::XMA_NIBBLE_EXCHANGE: begin
                res = '{value: {mem_reg[3:0], mem_reg[7:4]}, to_mem: 1'b1, to_work: 1'b0, skip: 1'b0};
            end
            xma_pkg::XMA_NIBBLE_EXCHANGE_TO_WORK: begin
                res = '{value: {mem_reg[3:0], mem_reg[7:4]}, to_mem: 1'b0, to_work: 1'b1, skip: 1'b0};
            end
            default: begin
                // unknown code: no write, no flag change
                res = '0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // sequencer: exec takes one cycle, a taken skip adds one dummy cycle
    // ----------------------------------------------------------------
    logic start;
    assign start = wr_ok & (paddr_in == `XMA_OFF_CMD);
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg <= xma_pkg::XMA_IDLE;
        end else begin
            case (state_reg)
                xma_pkg::XMA_IDLE: begin
                    if (start) begin
                        state_reg <= xma_pkg::XMA_EXEC;
                    end
                end
                xma_pkg::XMA_EXEC: begin
                    // dummy slot only when the skip is taken
                    state_reg <= res.skip ? xma_pkg::XMA_DUMMY : xma_pkg::XMA_IDLE;
                end
                xma_pkg::XMA_DUMMY: begin
                    state_reg <= xma_pkg::XMA_IDLE;
                end
                default: begin
                    state_reg <= xma_pkg::XMA_IDLE;
                end
            endcase
        end
    end

    // instruction cycle count: idle issue + exec + dummy = three on skip
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cyc_reg  <= 2'h0;
            skip_reg <= 1'b0;
        end else if (start) begin
            cyc_reg  <= 2'h1;
            skip_reg <= 1'b0;
        end else if (state_reg != xma_pkg::XMA_IDLE) begin
            cyc_reg <= cyc_reg + 2'h1;
            if (state_reg == xma_pkg::XMA_EXEC) begin
                skip_reg <= res.skip;
            end
        end
    end

    // command register
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            op_reg  <= 5'h00;
            bit_reg <= 3'h0;
        end else if (start) begin
            op_reg  <= pwdata_in[`XMA_CMD_OP_MSB:`XMA_CMD_OP_LSB];
            bit_reg <= pwdata_in[`XMA_CMD_BIT_MSB:`XMA_CMD_BIT_LSB];
        end
    end

    // working register: software load or result write
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            work_reg <= `XMA_RST_BYTE;
        end else if (wr_ok && paddr_in == `XMA_OFF_WORK) begin
            work_reg <= pwdata_in[7:0];
        end else if (state_reg == xma_pkg::XMA_EXEC && res.to_work) begin
            work_reg <= res.value;
        end
    end

    // memory byte: untouched by work-target forms
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mem_reg <= `XMA_RST_BYTE;
        end else if (wr_ok && paddr_in == `XMA_OFF_MEM) begin
            mem_reg <= pwdata_in[7:0];
        end else if (state_reg == xma_pkg::XMA_EXEC && res.to_mem) begin
            mem_reg <= res.value;
        end
    end

    // flags: software load, else only arithmetic and carry rotates change them
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flags_reg <= '0;
        end else if (wr_ok && paddr_in == `XMA_OFF_FLAGS) begin
            flags_reg <= pwdata_in[5:0];
        end else if (state_reg == xma_pkg::XMA_EXEC) begin
            flags_reg <= flags_next;
        end
    end

    // ----------------------------------------------------------------
    // read data and sequencer outputs
    // ----------------------------------------------------------------
    always_comb begin
        prdata_out = 32'h0000_0000;
        if (rd_en) begin
            case (paddr_in)
                `XMA_OFF_WORK:   prdata_out = {24'h000000, work_reg};
                `XMA_OFF_FLAGS:  prdata_out = {26'h0000000, flags_reg};
                `XMA_OFF_MEM:    prdata_out = {24'h000000, mem_reg};
                `XMA_OFF_CMD:    prdata_out = {21'h000000, bit_reg, 3'h0, op_reg};
                `XMA_OFF_RESULT: prdata_out = {24'h000000, res.value};
                `XMA_OFF_STATUS: prdata_out = {26'h0000000, cyc_reg, skip_reg, state_reg, 1'b0} >> 1;
                default:         prdata_out = 32'h0000_0000;
            endcase
        end
    end

    assign busy_out  = (state_reg != xma_pkg::XMA_IDLE);
    assign skip_out  = skip_reg;
    assign dummy_out = (state_reg == xma_pkg::XMA_DUMMY);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_rol_value: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        state_reg == xma_pkg::XMA_EXEC && op_reg == xma_pkg::XMA_MEM_ROTATE_LEFT
        |=> mem_reg == {$past(mem_reg[6:0]), $past(mem_reg[7])}) else $error("rotate left wrong");
    chk_work_keeps_mem: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        state_reg == xma_pkg::XMA_EXEC && res.to_work |=> $stable(mem_reg)) else $error("memory changed");
    chk_rlc_carry: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        state_reg == xma_pkg::XMA_EXEC && op_reg == xma_pkg::XMA_ROTATE_LEFT_THRU_CARRY
        |=> flags_reg.carry == $past(mem_reg[7]) && mem_reg[0] == $past(flags_reg.carry)) else $error("rlc wrong");
    chk_rrc_carry: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        state_reg == xma_pkg::XMA_EXEC && op_reg == xma_pkg::XMA_ROTATE_RIGHT_THRU_CARRY
        |=> flags_reg.carry == $past(mem_reg[0]) && mem_reg[7] == $past(flags_reg.carry)) else $error("rrc wrong");
    chk_sub_carry: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        state_reg == xma_pkg::XMA_EXEC && op_reg == xma_pkg::XMA_PLAIN_SUBTRACT
        |=> flags_reg.carry == ($past(work_reg) >= $past(mem_reg))) else $error("sub carry wrong");
    chk_skip_three: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        state_reg == xma_pkg::XMA_EXEC && res.skip |=> dummy_out ##1 !busy_out && cyc_reg == `XMA_SKIP_CYCLES)
        else $error("skip not three cycles");
    chk_set_all: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        state_reg == xma_pkg::XMA_EXEC && op_reg == xma_pkg::XMA_SET_ALL_BITS
        |=> mem_reg == `XMA_ALL_ONES && $stable(flags_reg)) else $error("set all wrong");
    chk_swap_nib: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        state_reg == xma_pkg::XMA_EXEC && op_reg == xma_pkg::XMA_NIBBLE_EXCHANGE
        |=> mem_reg == {$past(mem_reg[3:0]), $past(mem_reg[7:4])}) else $error("swap wrong");

    cov_skip: cover property (@(posedge mclk_in) disable iff (!rst_b_in) dummy_out);
    cov_sub_neg: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
        state_reg == xma_pkg::XMA_EXEC && diff[8]);
    cov_dec_zero: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
        state_reg == xma_pkg::XMA_EXEC && op_reg == xma_pkg::XMA_DECREMENT_SKIP_ZERO && res.skip);
endmodule

// ==== test/xma_apb_host.sv ====
`timescale 1ns/100ps
// apb master standing in for the core sequencer that issues the operations
module xma_apb_host (
    // clock
    input  wire logic        mclk_in,
    // apb request
    output logic             psel_out,
    output logic             penable_out,
    output logic             pwrite_out,
    output logic      [11:0] paddr_out,
    output logic      [31:0] pwdata_out,
    // apb answer
    input  wire logic [31:0] prdata_in,
    input  wire logic        pready_in,
    input  wire logic        pslverr_in
);
    logic chain_next = 1'b0;   // set by the bench: the next setup follows this access at once
    logic chained    = 1'b0;   // the previous access kept psel high, so no idle edge first

    // idle bus from time zero
    initial begin
        psel_out    = 1'b0;
        penable_out = 1'b0;
        pwrite_out  = 1'b0;
        paddr_out   = 12'h000;
        pwdata_out  = 32'h0000_0000;
    end

    // one whole transfer: held until pready is seen high at a rising edge
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        // a chained transfer drives its setup in the same step as the last access
        if (!chained) begin
            @(posedge mclk_in);
        end
        psel_out    <= 1'b1;
        penable_out <= 1'b0;
        pwrite_out  <= wr;
        paddr_out   <= a;
        pwdata_out  <= d;
        @(posedge mclk_in);
        penable_out <= 1'b1;
        // no wait count assumed: the bench watchdog ends a hang
        do @(posedge mclk_in); while (pready_in !== 1'b1);
        q = prdata_in;
        e = pslverr_in;
        chained    = chain_next;
        chain_next = 1'b0;
        // a chained transfer leaves psel up; the next call assigns the rest once
        if (!chained) begin
            psel_out    <= 1'b0;
            penable_out <= 1'b0;
            // released data no longer shows the old value
            pwdata_out  <= ~d;
        end
    endtask
endmodule

// ==== test/test_extended_mem_alu_ops.sv ====
`timescale 1ns/100ps
`include "xma_map.svh"
module test_extended_mem_alu_ops;
    // ------------------------------------------------------------
    // clock, reset, wires
    // ------------------------------------------------------------
    logic        mclk_in  = 1'b0;
    logic        rst_b_in = 1'b0;
    wire logic   psel, penable, pwrite, pready, pslverr, busy, skip, dummy;
    wire logic [11:0] paddr;
    wire logic [31:0] pwdata, prdata;
    int          err_total = 0;
    int          checks    = 0;
    int          dummies   = 0;   // dummy cycles seen, tells a taken skip apart
    int          busies    = 0;   // busy cycles seen: one exec, plus the dummy on a skip
    logic [7:0]  sw [4] = '{8'h35, 8'h02, 8'h80, 8'h00};
    logic [7:0]  sm [4] = '{8'h80, 8'h01, 8'h01, 8'hff};
    logic [5:0]  sf [4] = '{6'h3f, 6'h20, 6'h00, 6'h01};

    always #12.5 mclk_in = ~mclk_in;
    always @(posedge mclk_in) if (dummy === 1'b1) dummies++;
    always @(posedge mclk_in) if (busy === 1'b1) busies++;

    xma_core dut_u (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .busy_out(busy), .skip_out(skip), .dummy_out(dummy));
    xma_apb_host host_u (.mclk_in(mclk_in), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
        .paddr_out(paddr), .pwdata_out(pwdata), .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // reference result {skip, flags, work, mem}; borrow forms use the inverted carry
    function automatic logic [22:0] ref_op(input logic [4:0] op, input logic [2:0] b,
                                           input logic [7:0] w, input logic [7:0] m, input logic [5:0] f);
        logic [8:0] d;
        logic [4:0] h;
        logic [7:0] r, nw, nm;
        logic [5:0] nf;
        logic       sk, bw, v;
        nw = w;
        nm = m;
        nf = f;
        sk = 1'b0;
        bw = (op < 5'h0a) ? ~f[0] : 1'b0;
        d  = {1'b0, w} - {1'b0, m} - bw;
        h  = {1'b0, w[3:0]} - {1'b0, m[3:0]} - bw;
        r  = d[7:0];
        v  = (w[7] != m[7]) && (r[7] != w[7]);
        case (op)
            0, 1: r = {m[6:0], m[7]};
            2, 3: begin
                r     = {m[6:0], f[0]};
                nf[0] = m[7];
            end
            4, 5: r = {m[0], m[7:1]};
            6, 7: begin
                r     = {f[0], m[7:1]};
                nf[0] = m[0];
            end
            8, 9, 10, 11: nf = {(op < 5'h0a) ? (r == 0) & f[5] : (r == 0), r[7] ^ v, v, r == 0, ~h[4], ~d[8]};
            12, 13: begin
                r  = m - 8'h01;
                sk = (r == 0);
            end
            14, 15: begin
                r  = m + 8'h01;
                sk = (r == 0);
            end
            16: r = 8'hff;
            17: begin
                r    = m;
                r[b] = 1'b1;
            end
            18: begin
                r  = m;
                sk = m[b];
            end
            19: begin
                r  = m;
                sk = (m != 0);
            end
            default: r = {m[3:0], m[7:4]};
        endcase
        if (op inside {1, 3, 5, 7, 8, 10, 13, 15, 21}) nw = r;
        else nm = r;
        return {sk, nf, nw, nm};
    endfunction

    // one operation through the registers, then work, mem, flags, skip, dummy and busy compared
    task automatic run(input logic [4:0] op, input logic [2:0] b, input int s);
        logic [31:0] q;
        logic        e;
        logic [22:0] x;
        int          d0;
        int          b0;
        x = ref_op(op, b, sw[s], sm[s], sf[s]);
        host_u.xfer(1'b1, `XMA_OFF_WORK, {24'h0, sw[s]}, q, e);
        host_u.xfer(1'b1, `XMA_OFF_MEM, {24'h0, sm[s]}, q, e);
        host_u.xfer(1'b1, `XMA_OFF_FLAGS, {26'h0, sf[s]}, q, e);
        d0 = dummies;
        b0 = busies;
        host_u.xfer(1'b1, `XMA_OFF_CMD, {21'h0, b, 3'h0, op}, q, e);
        repeat (8) begin
            host_u.xfer(1'b0, `XMA_OFF_STATUS, 32'h0, q, e);
            if (q[1:0] === 2'b00) break;
        end
        // a poll limit that runs out is a mismatch
        chk("idle", 32'h0000_0000, {30'h0, q[1:0]});
        host_u.xfer(1'b0, `XMA_OFF_WORK, 32'h0, q, e);
        chk("work", x[15:8], q[7:0]);
        host_u.xfer(1'b0, `XMA_OFF_MEM, 32'h0, q, e);
        chk("mem", x[7:0], q[7:0]);
        host_u.xfer(1'b0, `XMA_OFF_FLAGS, 32'h0, q, e);
        chk("flags", x[21:16], q[5:0]);
        chk("skip", x[22], skip);
        chk("dummy", x[22] ? 1 : 0, dummies - d0);
        chk("busy", x[22] ? 2 : 1, busies - b0);
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        logic [31:0] q;
        logic        e;
        repeat (8) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        host_u.xfer(1'b0, `XMA_OFF_STATUS, 32'h0, q, e);
        chk("status after reset", 32'h0, q);
        // every code against four operand sets, bit index varied
        for (int i = 0; i < 22; i++) begin
            for (int s = 0; s < 4; s++) begin
                run(5'(i), 3'(i + 3 * s), s);
            end
        end
        $display("test operations done");
        // a write landing in the dummy slot of a taken skip is refused and changes nothing
        host_u.xfer(1'b1, `XMA_OFF_WORK, 32'h0000_0002, q, e);
        host_u.xfer(1'b1, `XMA_OFF_MEM, 32'h0000_0001, q, e);
        host_u.chain_next = 1'b1;
        host_u.xfer(1'b1, `XMA_OFF_CMD, {27'h0, 5'h0c}, q, e);
        host_u.xfer(1'b1, `XMA_OFF_WORK, 32'h0000_005a, q, e);
        chk("busy write err", 1'b1, e);
        host_u.xfer(1'b0, `XMA_OFF_WORK, 32'h0, q, e);
        chk("busy write kept", 32'h0000_0002, q);
        host_u.xfer(1'b0, `XMA_OFF_MEM, 32'h0, q, e);
        chk("busy write mem", 32'h0000_0000, q);
        $display("test refused write done");
        // unmapped place answers with an error and reads zero
        host_u.xfer(1'b0, 12'h020, 32'h0, q, e);
        chk("unmapped err", 1'b1, e);
        chk("unmapped data", 32'h0, q);
        $display("test unmapped done");
        wrap_up();
    end

    // watchdog sized well past the expected run of some 2150 cycles
    initial begin
        #(25 * 20000);
        err_total++;
        $display("watchdog expired");
        wrap_up();
    end
endmodule
